//--- hw/sgc_pkg.sv
// sgc_pkg: constants shared by the host and device ends of the seek/geometry pair
// assumes both ends run on one 50 MHz clock with an active-low async reset
`default_nettype none
package sgc_pkg;
	// timing
	localparam int CLK_NS = 20;
	localparam int SEEK_NS = 2000;
	localparam int SETTLE_NS = 200;
	localparam int SAVE_NS = 100;
	localparam logic [15:0] SEEK_CYC = 16'((SEEK_NS + CLK_NS - 1) / CLK_NS);
	localparam logic [15:0] SETTLE_CYC = 16'((SETTLE_NS + CLK_NS - 1) / CLK_NS);
	localparam logic [15:0] SAVE_CYC = 16'((SAVE_NS + CLK_NS - 1) / CLK_NS);
	// task-file offsets
	localparam logic [9:0] TF_FEAT = 10'h1F1;
	localparam logic [9:0] TF_SC = 10'h1F2;
	localparam logic [9:0] TF_SN = 10'h1F3;
	localparam logic [9:0] TF_CL = 10'h1F4;
	localparam logic [9:0] TF_CH = 10'h1F5;
	localparam logic [9:0] TF_DH = 10'h1F6;
	localparam logic [9:0] TF_CMD = 10'h1F7;
	// status, error and drive/head fields
	localparam int ST_BUSY = 7;
	localparam int ST_RDY = 6;
	localparam int ST_DSC = 4;
	localparam int ST_ERR = 0;
	localparam int ER_ABRT = 2;
	localparam int ER_IDNF = 4;
	localparam int DH_LBA = 6;
	localparam int DH_DRV = 4;
	// commands
	localparam logic [3:0] CMD_SEEK_HI = 4'h7;
	localparam logic [7:0] CMD_GEO = 8'h91;
	localparam logic [7:0] GEO_BAD_SC = 8'h00;
	// geometry after power-up, the default capacity area and the drive select value
	localparam logic [7:0] DEF_SPT = 8'h3F;
	localparam logic [3:0] DEF_MAXH = 4'hF;
	localparam logic [27:0] DEF_CAP = 28'h0100000;
	localparam logic DEV_SEL = 1'b0;
	// controller registers on the AXI4-Lite side
	localparam logic [7:0] A_CTRL = 8'h00;
	localparam logic [7:0] A_CMDA = 8'h04;
	localparam logic [7:0] A_CMDB = 8'h08;
	localparam logic [7:0] A_STAT = 8'h0C;
	localparam logic [7:0] A_RES = 8'h10;
	localparam logic [7:0] A_IRQS = 8'h14;
	localparam logic [7:0] A_IRQM = 8'h18;
	localparam int CTRL_GO = 0;
	localparam int CTRL_SRST = 1;
	localparam int IRQ_DONE = 0;
	localparam int IRQ_ERR = 1;
	localparam logic [1:0] RESP_OK = 2'h0;
	localparam logic [1:0] RESP_DEC = 2'h3;
	localparam logic [2:0] LAST_IDX = 3'h5;
endpackage : sgc_pkg
`default_nettype wire

//--- hw/sgc_if.sv
// sgc_if: task-file register port between controller and drive
// assumes both ends clocked by the same clock; all signals are plain logic
`default_nettype none
interface sgc_if;
	logic [9:0] addr;
	logic [7:0] wdata;
	logic wr;
	logic rd;
	logic srst;
	logic [7:0] rdata;
	logic intrq;
	modport dev (input addr, input wdata, input wr, input rd, input srst,
		output rdata, output intrq);
	modport host (output addr, output wdata, output wr, output rd, output srst,
		input rdata, input intrq);
endinterface : sgc_if
`default_nettype wire

//--- hw/sgc_dev.sv
// sgc_dev: drive end; task-file registers, seek and geometry commands
// assumes the controller end shares the clock, so no synchronisers are needed
//
// Behaviour
// R1: command 7x starts a seek to given position
// R2: seek done clears busy, raises interrupt
// R3: seek-complete status bit always reads one
// R4: lba mode seeks to sector's cylinder/head
// R5: position from drive/head and cylinder registers
// R6: code 91 loads spt and max head
// R7: host sends max head as heads minus one
// R8: geometry command: busy, store, release, interrupt
// R9: zero sector count aborts geometry command
// R10: stored geometry survives reset and power save; here only controller reset keeps it, resetn reloads DEF_SPT and DEF_MAXH
// R11: geometry command ignores the lba bit
// R12: lba seeks stay inside default capacity
// R13: host may read capacity from identify data; no identify command here, it aborts as unsupported
// R14: error details readable in error register
// R15: geometry abort also sets status error bit
// R16: commands act only when drive selected
`default_nettype none
module sgc_dev
	import sgc_pkg::*;
(
	input wire logic clock,
	input wire logic resetn,
	sgc_if.dev tf,
	output logic [15:0] cyl_pos,
	output logic [3:0] head_pos
);
	typedef enum logic [1:0] {
		D_IDLE = 2'b00,
		D_SEEK = 2'b01,
		D_GEO = 2'b10
	} sgc_dstate_t;

	typedef struct packed {
		sgc_dstate_t fsm;
		logic [15:0] cnt;
		logic [7:0] feat;
		logic [7:0] err;
		logic [7:0] sc;
		logic [7:0] sn;
		logic [7:0] cl;
		logic [7:0] ch;
		logic [7:0] dh;
		logic [7:0] rdata;
		logic errf;
		logic intrq;
		logic [7:0] spt;
		logic [3:0] maxh;
		logic [15:0] cyl;
		logic [3:0] head;
	} sgc_dev_st_t;

	localparam sgc_dev_st_t RST = '{fsm: D_IDLE, spt: DEF_SPT, maxh: DEF_MAXH, default: '0};

	sgc_dev_st_t r;
	sgc_dev_st_t n;
	logic [27:0] lba;
	logic [27:0] nh;
	logic [27:0] trk;
	logic [15:0] t_cyl;
	logic [3:0] t_head;
	logic out_rng;
	logic [7:0] sbyte;

	// the divider is combinational; its result also picks seek or settle time in the command-write cycle
	always_comb begin
		n = r;
		lba = {r.dh[3:0], r.ch, r.cl, r.sn};
		nh = {24'h0, r.maxh} + 28'h1;
		trk = lba / {20'h0, r.spt};
		if (r.dh[DH_LBA]) begin
			t_cyl = 16'(trk / nh); // R4
			t_head = 4'(trk % nh); // R4
		end else begin
			t_cyl = {r.ch, r.cl}; // R5
			t_head = r.dh[3:0]; // R5
		end
		out_rng = r.dh[DH_LBA] && (lba >= DEF_CAP); // R12
		sbyte = '0;
		sbyte[ST_BUSY] = (r.fsm != D_IDLE);
		sbyte[ST_RDY] = (r.fsm == D_IDLE);
		sbyte[ST_DSC] = 1'b1; // R3
		sbyte[ST_ERR] = r.errf;

		// reads: status read acknowledges the interrupt
		if (tf.rd) begin
			unique case (tf.addr)
				TF_FEAT: n.rdata = r.err; // R14
				TF_SC: n.rdata = r.sc;
				TF_SN: n.rdata = r.sn;
				TF_CL: n.rdata = r.cl;
				TF_CH: n.rdata = r.ch;
				TF_DH: n.rdata = r.dh;
				TF_CMD: begin
					n.rdata = sbyte;
					n.intrq = 1'b0;
				end
				default: n.rdata = 8'h00;
			endcase
		end

		unique case (r.fsm)
			D_IDLE: begin
				// writes while busy are dropped so parameters stay stable
				if (tf.wr) begin
					unique case (tf.addr)
						TF_FEAT: n.feat = tf.wdata;
						TF_SC: n.sc = tf.wdata;
						TF_SN: n.sn = tf.wdata;
						TF_CL: n.cl = tf.wdata;
						TF_CH: n.ch = tf.wdata;
						TF_DH: n.dh = tf.wdata;
						TF_CMD: begin
							if (r.dh[DH_DRV] == DEV_SEL) begin // R16
								n.errf = 1'b0;
								n.err = '0;
								n.intrq = 1'b0;
								if (tf.wdata[7:4] == CMD_SEEK_HI) begin // R1
									n.fsm = D_SEEK;
									if (t_cyl == r.cyl) begin
										n.cnt = SETTLE_CYC;
									end else begin
										n.cnt = SEEK_CYC;
									end
								end else if (tf.wdata == CMD_GEO) begin // R6
									n.fsm = D_GEO; // R8
									n.cnt = SAVE_CYC;
								end else begin
									// unsupported codes end at once as aborted
									n.errf = 1'b1;
									n.err[ER_ABRT] = 1'b1; // R14
									n.intrq = 1'b1;
								end
							end
						end
						default: ;
					endcase
				end
			end
			D_SEEK, D_GEO: begin
				if (r.cnt != 16'h0) begin
					n.cnt = r.cnt - 16'h1;
				end else begin
					n.fsm = D_IDLE; // R2 R8
					n.intrq = 1'b1; // R2 R8
					if (r.fsm == D_SEEK) begin
						if (out_rng) begin
							n.errf = 1'b1; // R12
							n.err[ER_IDNF] = 1'b1; // R14
						end else begin
							// task-file registers are not updated; in lba mode they keep the sector number, not the reached position
							n.cyl = t_cyl; // R5
							n.head = t_head; // R5
						end
					end else if (r.sc == GEO_BAD_SC) begin
						n.errf = 1'b1; // R15
						n.err[ER_ABRT] = 1'b1; // R9
					end else begin
						n.spt = r.sc; // R8
						n.maxh = r.dh[3:0]; // R11
					end
				end
			end
			default: n.fsm = D_IDLE;
		endcase

		// controller reset clears the command state but never the geometry
		if (tf.srst) begin
			n = RST;
			n.spt = r.spt; // R10
			n.maxh = r.maxh; // R10
			n.cyl = r.cyl;
			n.head = r.head;
		end
	end

	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			r <= RST;
		end else begin
			r <= n;
		end
	end

	assign tf.rdata = r.rdata;
	assign tf.intrq = r.intrq;
	assign cyl_pos = r.cyl;
	assign head_pos = r.head;
endmodule : sgc_dev
`default_nettype wire

//--- hw/sgc_host.sv
// sgc_host: controller end; AXI4-Lite registers drive one task-file command
// assumes the drive end shares the clock; AXI master keeps one transfer per channel
`default_nettype none
module sgc_host
	import sgc_pkg::*;
(
	input wire logic clock,
	input wire logic resetn,
	input wire logic [7:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [7:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	sgc_if.host tf,
	output logic irq
);
	typedef enum logic [2:0] {
		H_IDLE = 3'b000,
		H_WR = 3'b001,
		H_WAIT = 3'b010,
		H_RD = 3'b011,
		H_RGAP = 3'b100,
		H_CAP = 3'b101
	} sgc_hstate_t;

	typedef struct packed {
		sgc_hstate_t fsm;
		logic [2:0] idx;
		logic awr;
		logic bvalid;
		logic [1:0] bresp;
		logic arready;
		logic rvalid;
		logic [1:0] rresp;
		logic [31:0] rdata;
		logic [31:0] cmda;
		logic [31:0] cmdb;
		logic busy;
		logic [7:0] stat;
		logic [7:0] err;
		logic [31:0] res;
		logic [1:0] ist;
		logic [1:0] imsk;
		logic irq;
		logic [9:0] addr;
		logic [7:0] wdata;
		logic wr;
		logic rd;
		logic srst;
	} sgc_host_st_t;

	localparam sgc_host_st_t RST = '{fsm: H_IDLE, default: '0};

	function automatic logic [31:0] merge(input logic [31:0] o, input logic [31:0] d,
		input logic [3:0] s);
		logic [31:0] m;
		m = o;
		for (int i = 0; i < 4; i++) begin
			if (s[i]) m[8*i +: 8] = d[8*i +: 8];
		end
		return m;
	endfunction : merge

	sgc_host_st_t r;
	sgc_host_st_t n;
	logic [1:0] set;
	logic [1:0] clr;
	logic [7:0] wbyte;
	logic [9:0] raddr;

	always_comb begin
		n = r;
		set = '0;
		clr = '0;
		n.awr = 1'b0;
		n.arready = 1'b0;
		n.wr = 1'b0;
		n.rd = 1'b0;
		n.srst = 1'b0;
		if (r.bvalid && s_axi_bready) n.bvalid = 1'b0;
		if (r.rvalid && s_axi_rready) n.rvalid = 1'b0;
		unique case (r.idx)
			3'h0: wbyte = r.cmda[15:8]; // R6
			3'h1: wbyte = r.cmda[23:16];
			3'h2: wbyte = r.cmdb[7:0];
			3'h3: wbyte = r.cmdb[15:8];
			// geometry takes a head count and sends it as the top head index
			3'h4: wbyte = (r.cmda[7:0] == CMD_GEO) ?
				{r.cmda[31:28], 4'(r.cmdb[23:16] - 8'h1)} : r.cmda[31:24]; // R7
			default: wbyte = r.cmda[7:0]; // R1
		endcase
		unique case (r.idx)
			3'h0: raddr = TF_CMD;
			3'h1: raddr = TF_FEAT;
			3'h2: raddr = TF_SN;
			3'h3: raddr = TF_CL;
			3'h4: raddr = TF_CH;
			default: raddr = TF_DH;
		endcase
		// both address and data are taken on one edge; response follows next cycle
		if (s_axi_awvalid && s_axi_wvalid && !r.bvalid && !r.awr) begin
			n.awr = 1'b1;
			n.bvalid = 1'b1;
			n.bresp = RESP_OK;
			unique case (s_axi_awaddr)
				A_CTRL: begin
					if (s_axi_wstrb[0] && s_axi_wdata[CTRL_GO] && r.fsm == H_IDLE) begin
						n.fsm = H_WR;
						n.idx = '0;
						n.busy = 1'b1;
					end
					if (s_axi_wstrb[0] && s_axi_wdata[CTRL_SRST]) n.srst = 1'b1;
				end
				A_CMDA: n.cmda = merge(r.cmda, s_axi_wdata, s_axi_wstrb);
				A_CMDB: n.cmdb = merge(r.cmdb, s_axi_wdata, s_axi_wstrb);
				A_IRQS: if (s_axi_wstrb[0]) clr = s_axi_wdata[1:0];
				A_IRQM: if (s_axi_wstrb[0]) n.imsk = s_axi_wdata[1:0];
				A_STAT, A_RES: ;
				default: n.bresp = RESP_DEC;
			endcase
		end
		if (s_axi_arvalid && !r.rvalid && !r.arready) begin
			n.arready = 1'b1;
			n.rvalid = 1'b1;
			n.rresp = RESP_OK;
			unique case (s_axi_araddr)
				A_CTRL: n.rdata = {31'h0, r.busy};
				A_CMDA: n.rdata = r.cmda;
				A_CMDB: n.rdata = r.cmdb;
				A_STAT: n.rdata = {16'h0, r.err, r.stat};
				A_RES: n.rdata = r.res;
				A_IRQS: n.rdata = {30'h0, r.ist};
				A_IRQM: n.rdata = {30'h0, r.imsk};
				default: begin
					n.rdata = '0;
					n.rresp = RESP_DEC;
				end
			endcase
		end
		unique case (r.fsm)
			H_IDLE: ;
			H_WR: begin
				n.wr = 1'b1;
				n.addr = TF_SC + 10'(r.idx);
				n.wdata = wbyte;
				n.idx = r.idx + 3'h1;
				if (r.idx == LAST_IDX) begin
					n.fsm = H_WAIT;
					n.idx = '0;
				end
			end
			H_WAIT: if (tf.intrq) n.fsm = H_RD; // R2
			H_RD: begin
				n.rd = 1'b1;
				n.addr = raddr;
				n.fsm = H_RGAP;
			end
			// the drive registers read data, so capture two edges later
			H_RGAP: n.fsm = H_CAP;
			H_CAP: begin
				unique case (r.idx)
					3'h0: n.stat = tf.rdata;
					3'h1: n.err = tf.rdata;
					3'h2: n.res[7:0] = tf.rdata;
					3'h3: n.res[15:8] = tf.rdata;
					3'h4: n.res[23:16] = tf.rdata;
					default: n.res[31:24] = tf.rdata;
				endcase
				n.idx = r.idx + 3'h1;
				n.fsm = H_RD;
				if (r.idx == LAST_IDX) begin
					n.fsm = H_IDLE;
					n.idx = '0;
					n.busy = 1'b0;
					set[IRQ_DONE] = 1'b1;
					set[IRQ_ERR] = r.stat[ST_ERR];
				end
			end
			default: n.fsm = H_IDLE;
		endcase
		if (n.srst) begin
			n.fsm = H_IDLE;
			n.busy = 1'b0;
		end
		// a new event beats a write-one-to-clear in the same cycle
		n.ist = (r.ist & ~clr) | set;
		n.irq = |(n.ist & n.imsk);
	end

	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			r <= RST;
		end else begin
			r <= n;
		end
	end

	assign s_axi_awready = r.awr;
	assign s_axi_wready = r.awr;
	assign s_axi_bresp = r.bresp;
	assign s_axi_bvalid = r.bvalid;
	assign s_axi_arready = r.arready;
	assign s_axi_rdata = r.rdata;
	assign s_axi_rresp = r.rresp;
	assign s_axi_rvalid = r.rvalid;
	assign tf.addr = r.addr;
	assign tf.wdata = r.wdata;
	assign tf.wr = r.wr;
	assign tf.rd = r.rd;
	assign tf.srst = r.srst;
	assign irq = r.irq;
endmodule : sgc_host
`default_nettype wire

//--- dv/sgc_properties.sv
// sgc_properties: assertions on the task-file link between the two ends
// assumes one clock domain; the testbench wires the interface signals in
`default_nettype none
module sgc_properties
	import sgc_pkg::*;
(
	input wire logic clock,
	input wire logic resetn,
	input wire logic [9:0] addr,
	input wire logic [7:0] wdata,
	input wire logic wr,
	input wire logic rd,
	input wire logic srst,
	input wire logic [7:0] rdata,
	input wire logic intrq
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [7:0] dh_reg;
	logic [7:0] sc_reg;
	logic [7:0] cmd_reg;
	logic [15:0] cnt_reg;
	wire logic go = wr && addr == TF_CMD && dh_reg[DH_DRV] == DEV_SEL;
	wire logic st_rd = rd && addr == TF_CMD;
	// saturating, so a lost interrupt never wraps into a plausible count
	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			dh_reg <= 8'h00;
			sc_reg <= 8'h00;
			cmd_reg <= 8'h00;
			cnt_reg <= 16'hFFFF;
		end else begin
			if (wr && addr == TF_DH)
				dh_reg <= wdata;
			if (wr && addr == TF_SC)
				sc_reg <= wdata;
			if (go)
				cmd_reg <= wdata;
			if (go)
				cnt_reg <= 16'h0000;
			else if (srst)
				cnt_reg <= 16'hFFFF;
			else if (cnt_reg != 16'hFFFF)
				cnt_reg <= cnt_reg + 16'h0001;
		end
	end
	default clocking @(posedge clock);
	endclocking
	default disable iff (!resetn);
	sequence s_rest;
		wr && addr == TF_SN ##1 wr && addr == TF_CL ##1 wr && addr == TF_CH
			##1 wr && addr == TF_DH ##1 wr && addr == TF_CMD;
	endsequence
	property p_order;
		wr && addr == TF_SC |=> s_rest;
	endproperty
	property p_dsc;
		st_rd |=> rdata[ST_DSC];
	endproperty
	property p_rdy;
		st_rd |=> rdata[ST_BUSY] != rdata[ST_RDY];
	endproperty
	property p_clr;
		st_rd |-> ##[1:2] !intrq;
	endproperty
	property p_seek_t;
		$rose(intrq) && cmd_reg[7:4] == CMD_SEEK_HI && !dh_reg[DH_LBA]
			|-> cnt_reg >= SETTLE_CYC && cnt_reg <= SEEK_CYC + 16'd3;
	endproperty
	property p_geo_t;
		$rose(intrq) && cmd_reg == CMD_GEO && sc_reg != GEO_BAD_SC
			|-> cnt_reg >= SAVE_CYC - 16'd1 && cnt_reg <= SAVE_CYC + 16'd3;
	endproperty
	property p_abort;
		go && wdata == CMD_GEO && sc_reg == GEO_BAD_SC |-> ##[1:8] intrq;
	endproperty
	property p_nosel;
		wr && addr == TF_CMD && dh_reg[DH_DRV] != DEV_SEL |=> $stable(intrq) [*8];
	endproperty
	a_order: assert property (p_order) else $error("command block out of order");
	a_dsc: assert property (p_dsc) else $error("seek complete bit low");
	a_rdy: assert property (p_rdy) else $error("busy and ready disagree");
	a_clr: assert property (p_clr) else $error("interrupt kept after status read");
	a_seek_t: assert property (p_seek_t) else $error("seek time wrong");
	a_geo_t: assert property (p_geo_t) else $error("geometry time wrong");
	a_abort: assert property (p_abort) else $error("zero count not ended");
	a_nosel: assert property (p_nosel) else $error("other drive command acted");
endmodule : sgc_properties
`default_nettype wire

//--- dv/testbench.sv
// testbench: controller and drive joined by sgc_if, driven over AXI4-Lite
// assumes 50 MHz clock and the controller's one-cycle AXI answers
`default_nettype none
module testbench
	import sgc_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;
	logic clock = 1'b0;
	logic resetn = 1'b0;
	logic [7:0] s_axi_awaddr = 8'h00;
	logic [7:0] s_axi_araddr = 8'h00;
	logic [31:0] s_axi_wdata = 32'h00000000;
	logic [3:0] s_axi_wstrb = 4'hF;
	logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
	logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, irq;
	logic [1:0] s_axi_bresp, s_axi_rresp;
	logic [31:0] s_axi_rdata;
	logic [15:0] cyl_pos;
	logic [3:0] head_pos;
	int fail_count = 0;
	int n_compared = 0;
	sgc_if tf_if ();
	sgc_host sgc_host_inst (.clock, .resetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
		.s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
		.s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
		.s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .tf(tf_if.host), .irq);
	sgc_dev sgc_dev_inst (.clock, .resetn, .tf(tf_if.dev), .cyl_pos, .head_pos);
	sgc_properties sgc_properties_inst (.clock, .resetn, .addr(tf_if.addr),
		.wdata(tf_if.wdata), .wr(tf_if.wr), .rd(tf_if.rd), .srst(tf_if.srst),
		.rdata(tf_if.rdata), .intrq(tf_if.intrq));
	always #10 clock = ~clock;
	task automatic conclude();
		if (fail_count == 0 && n_compared > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask : conclude
	task automatic chk(input logic [31:0] s, e);
		n_compared++;
		if (s !== e) begin
			fail_count++;
			$display("[FAIL] %0t seen %h expected %h", $time, s, e);
		end
	endtask : chk
	task automatic axw(input logic [7:0] a, input logic [31:0] v, input logic [1:0] e);
		@(posedge clock);
		s_axi_awaddr <= a;
		s_axi_wdata <= v;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		do @(posedge clock); while (!s_axi_awready);
		s_axi_awvalid <= 1'b0;
		s_axi_wvalid <= 1'b0;
		while (!s_axi_bvalid) @(posedge clock);
		s_axi_bready <= 1'b0;
		chk(s_axi_bresp, e);
	endtask : axw
	task automatic axr(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
		@(posedge clock);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do @(posedge clock); while (!s_axi_arready);
		s_axi_arvalid <= 1'b0;
		while (!s_axi_rvalid) @(posedge clock);
		d = s_axi_rdata;
		r = s_axi_rresp;
		s_axi_rready <= 1'b0;
	endtask : axr
	task automatic rchk(input logic [7:0] a, input logic [31:0] m, e);
		logic [31:0] d;
		logic [1:0] r;
		axr(a, d, r);
		chk(d & m, e);
	endtask : rchk
	// busy is polled, so an unknown busy bit keeps waiting until the watchdog
	task automatic run(input logic [31:0] ca, cb);
		logic [31:0] d;
		logic [1:0] r;
		axw(A_CMDA, ca, RESP_OK);
		axw(A_CMDB, cb, RESP_OK);
		axw(A_CTRL, 32'h1, RESP_OK);
		do axr(A_CTRL, d, r); while (d[0] !== 1'b0);
	endtask : run
	// geometry in force is 17 sectors per track and 8 heads
	task automatic seekl(input logic [27:0] l, input logic ok);
		logic [19:0] p;
		p = ok ? {16'(l / 136), 4'(l / 17 % 8)} : {cyl_pos, head_pos};
		run({4'hE, l[27:24], l[7:0], 8'h00, 8'h70}, {16'h0000, l[23:16], l[15:8]});
		chk({cyl_pos, head_pos}, p);
		rchk(A_STAT, 32'hFFFF, ok ? 32'h0050 : 32'h1051);
	endtask : seekl
	initial begin
		logic [31:0] d;
		logic [1:0] r;
		repeat (20) @(posedge clock);
		resetn <= 1'b1;
		rchk(A_IRQM, 32'hFFFFFFFF, 32'h0);
		axr(8'h1C, d, r);
		chk(r, RESP_DEC);
		axw(8'h1C, 32'h1, RESP_DEC);
		axw(A_IRQM, 32'h3, RESP_OK);
		run(32'hE0011191, 32'h00080000);
		rchk(A_STAT, 32'hFFFF, 32'h0050);
		rchk(A_RES, 32'h0F000000, 32'h07000000);
		chk(irq, 1'b1);
		rchk(A_IRQS, 32'h3, 32'h1);
		axw(A_IRQS, 32'h1, RESP_OK);
		rchk(A_IRQS, 32'h3, 32'h0);
		chk(irq, 1'b0);
		run(32'hA0000091, 32'h00080000);
		rchk(A_STAT, 32'hFFFF, 32'h0451);
		rchk(A_IRQS, 32'h3, 32'h3);
		run(32'hA0000020, 32'h00000000);
		rchk(A_STAT, 32'hFFFF, 32'h0451);
		axw(A_IRQS, 32'h3, RESP_OK);
		axw(A_IRQM, 32'h0, RESP_OK);
		for (int k = 0; k < 16; k++) begin
			run({4'hA, k[3:0], 16'h0100, 4'h7, k[3:0]}, {16'h0000, 8'h12, 4'h0, k[3:0]});
			chk({cyl_pos, head_pos}, {8'h12, 4'h0, k[3:0], k[3:0]});
		end
		rchk(A_STAT, 32'hFFFF, 32'h0050);
		chk(irq, 1'b0);
		rchk(A_IRQS, 32'h3, 32'h1);
		axw(A_IRQM, 32'h1, RESP_OK);
		rchk(A_IRQM, 32'h3, 32'h1);
		chk(irq, 1'b1);
		axw(A_IRQS, 32'h1, RESP_OK);
		seekl(28'd1000, 1'b1);
		axw(A_CTRL, 32'h2, RESP_OK);
		seekl(28'd2000, 1'b1);
		seekl(DEF_CAP - 28'd1, 1'b1);
		seekl(DEF_CAP, 1'b0);
		axw(A_CMDA, 32'hB0000070, RESP_OK);
		axw(A_CTRL, 32'h1, RESP_OK);
		repeat (300) @(posedge clock);
		chk({cyl_pos, head_pos}, {16'd7710, 4'd0});
		axw(A_CTRL, 32'h2, RESP_OK);
		rchk(A_CTRL, 32'h1, 32'h0);
		conclude();
	end
	initial begin
		repeat (30000) @(posedge clock);
		fail_count++;
		conclude();
	end
endmodule : testbench
`default_nettype wire
